// File: src/hgc_map.svh
// Register map, field positions, codes and timing figures of the gate control block
// Operation
// - Every frame's response carries all per-channel fault data, any address.
// - Address top bit set selects null register; data ignored, faults returned.
// - Gate high only with reset released, both enables, no short, and input or bit.
// - Second enable low forces gates low, keeps gate bits; resumes when high.
// - First enable low: gates low, timers stopped, faults and gate bits cleared.
// - First enable low discards gate bit writes, other registers still written.
// - Both enables high: gates follow parallel inputs and gate bits directly.
// - Diagnostics run only while both enables are high.
// - Shorted load checked when on; open load and ground short when off.
// - On-state fault protects output and latches code; off-state only latches.
// - Codes: 00 none, 01 open, 10 short to ground, 11 shorted load.
// - One read returns all six codes captured at one moment.
// - Command change starts on or off blanking; feedback sampled at expiry.
// - Threshold crossing in stable state starts filter; sampled at expiry.
// - Enable rise with other high, or both together, starts all blanking.
// - Per-channel timers, common durations for all channels.
// - Short threshold in four 25% steps, per group of three channels.
// - Shorted load recorded when feedback above threshold at blank or filter end.
// - Latch-off holds output off until host toggles input, bit or second enable.
// - Auto-retry: off for refresh time, back on, resample, repeat while faulted.
// - Mode bit 1 latch-off, 0 auto-retry; reset 0.
// - Group refresh bit: 0 about 10 ms, 1 about 40 ms; reset 10 ms.
// - One shared refresh timer with 10 and 40 ms taps, started by first channel in retry wait.
`ifndef HGC_MAP_SVH
`define HGC_MAP_SVH
`define HGC_CLK_MHZ 50
`define HGC_NCH 6
`define HGC_FRAME_BITS 16
`define HGC_ADDR_MSB 8
`define HGC_ADDR_LSB 6
`define HGC_DATA_MSB 5
`define HGC_ADDR_GATE 3'h0
`define HGC_ADDR_MODE 3'h1
`define HGC_ADDR_REFR 3'h2
`define HGC_ADDR_MASK 3'h3
`define HGC_ADDR_NULL 3'h4
`define HGC_REG_RESET 6'h00
`define HGC_REFR_SEL_LO 2
`define HGC_REFR_SEL_HI 5
`define HGC_FLT_NONE 2'h0
`define HGC_FLT_OPEN 2'h1
`define HGC_FLT_GND 2'h2
`define HGC_FLT_SHORT 2'h3
`define HGC_TURN_ON_BLANK_US 20
`define HGC_TURN_OFF_BLANK_US 20
`define HGC_GLITCH_FILTER_US 10
`define HGC_REFRESH_SHORT_MS 10
`define HGC_REFRESH_LONG_MS 40
`endif

// File: src/hgc_pkg.sv
// Types shared by the gate control block
package hgc_pkg;
   typedef enum logic [2:0] {CH_IDLE, CH_OFF_BL, CH_OFF_ST, CH_ON_BL, CH_ON_ST, CH_FILT, CH_WAIT, CH_LATCH} hgc_ch_st_t;
   typedef struct packed {
      hgc_ch_st_t st;
      logic [15:0] cnt;
      logic cmd_p;
      logic ab_p;
      logic shrt;
      logic [1:0] code;
   } hgc_ch_t;
   typedef struct packed {
      logic [3:0] cnt;
      logic [15:0] rx;
      logic [15:0] tx;
      logic [15:0] word;
      logic tgl;
      logic so;
   } hgc_ser_t;
   typedef struct packed {
      logic e1_m, e1_s, e2_m, e2_s, csb_m, csb_s, tg_m, tg_s, tg_p, en_p, diag;
      logic [5:0] in_m, in_s, os_m, os_s, op_m, op_s, gd_m, gd_s;
      logic [5:0] gsel, mode, refr, mask, gate;
      logic [11:0] snap;
      logic [21:0] rcnt;
      logic [1:0] rq;
   } hgc_top_t;
endpackage

// File: src/hgc_serial.sv
// Serial shift engine on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.svh"
module hgc_serial (
   input wire logic i_sclk,
   input wire logic i_rstn,
   input wire logic i_csb,
   input wire logic i_si,
   input wire logic [11:0] i_fault_data,
   output logic o_so,
   output logic [15:0] o_rx_word,
   output logic o_rx_tgl
);
   hgc_pkg::hgc_ser_t q, d;
   logic [15:0] eff;
   always_comb
   begin
      d = q;
      // Snapshot taken on first edge; core holds it still during frames
      eff = (q.cnt == 4'h0) ? {4'h0, i_fault_data} : q.tx;
      if (!i_csb)
      begin
         d.so = eff[14];
         d.tx = {eff[14:0], 1'b0};
         d.rx = {q.rx[14:0], i_si};
         d.cnt = q.cnt + 4'h1;
         if (q.cnt == 4'(`HGC_FRAME_BITS - 1))
         begin
            d.word = {q.rx[14:0], i_si};
            d.tgl = ~q.tgl;
         end
      end
   end
   always_ff @(posedge i_sclk or negedge i_rstn)
   begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end
   assign o_so = q.so;
   assign o_rx_word = q.word;
   assign o_rx_tgl = q.tgl;
   AST_SER_LEAD_ZERO: assert property (@(posedge i_sclk) disable iff (!i_rstn)
      (!i_csb && q.cnt == 4'h0) |=> (o_so == 1'b0 && q.tx[15:13] == 3'h0))
      else $error("response header not zero");
endmodule
`default_nettype wire

// File: src/hgc_chan.sv
// One channel: blanking, filter, fault latch and shorted-load recovery
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.svh"
module hgc_chan #(
   parameter logic [15:0] TURN_ON_BLANK = 16'h03E8,
   parameter logic [15:0] TURN_OFF_BLANK = 16'h03E8,
   parameter logic [15:0] GLITCH_FILTER = 16'h01F4
) (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_en,
   input wire logic i_clr,
   input wire logic i_start_all,
   input wire logic i_cmd,
   input wire logic i_over_short,
   input wire logic i_below_open,
   input wire logic i_below_gnd,
   input wire logic i_latch_mode,
   input wire logic i_tap,
   output logic o_shrt,
   output logic o_wait,
   output logic [1:0] o_code
);
   hgc_pkg::hgc_ch_t q, d;
   logic ab, lim;
   always_comb
   begin
      d = q;
      d.cmd_p = i_cmd;
      ab = i_cmd ? i_over_short : i_below_open;
      d.ab_p = ab;
      lim = 1'b0;
      if (i_clr)
         d.code = `HGC_FLT_NONE;
      d.cnt = q.cnt + 16'h1;
      case (q.st)
         hgc_pkg::CH_OFF_BL: lim = (q.cnt >= TURN_OFF_BLANK - 16'h1);
         hgc_pkg::CH_ON_BL: lim = (q.cnt >= TURN_ON_BLANK - 16'h1);
         hgc_pkg::CH_FILT: lim = (q.cnt >= GLITCH_FILTER - 16'h1);
         default: lim = 1'b0;
      endcase
      if (!i_en)
      begin
         // Diagnostics idle, recovery cleared by enable drop
         d.st = hgc_pkg::CH_IDLE;
         d.shrt = 1'b0;
      end
      else if (i_start_all || i_cmd != q.cmd_p)
      begin
         d.st = i_cmd ? hgc_pkg::CH_ON_BL : hgc_pkg::CH_OFF_BL;
         d.cnt = 16'h0;
         d.shrt = 1'b0;
      end
      else if (lim && ab)
      begin
         // Blank or filter end with abnormal feedback
         if (i_cmd)
         begin
            d.code = `HGC_FLT_SHORT;
            d.shrt = 1'b1;
            d.st = i_latch_mode ? hgc_pkg::CH_LATCH : hgc_pkg::CH_WAIT;
         end
         else
         begin
            d.code = i_below_gnd ? `HGC_FLT_GND : `HGC_FLT_OPEN;
            d.st = hgc_pkg::CH_OFF_ST;
         end
      end
      else if (lim)
         d.st = i_cmd ? hgc_pkg::CH_ON_ST : hgc_pkg::CH_OFF_ST;
      else
      begin
         case (q.st)
            hgc_pkg::CH_ON_ST, hgc_pkg::CH_OFF_ST:
            begin
               if (ab && !q.ab_p)
               begin
                  d.st = hgc_pkg::CH_FILT;
                  d.cnt = 16'h0;
               end
            end
            hgc_pkg::CH_WAIT:
            begin
               if (i_tap)
               begin
                  d.shrt = 1'b0;
                  d.st = hgc_pkg::CH_ON_BL;
                  d.cnt = 16'h0;
               end
            end
            default: d.st = q.st;
         endcase
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end
   assign o_shrt = q.shrt;
   assign o_wait = (q.st == hgc_pkg::CH_WAIT);
   assign o_code = q.code;
   AST_CH_ON_SHORT: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (q.st == hgc_pkg::CH_ON_BL && lim && i_over_short && i_en && !i_start_all && i_cmd == q.cmd_p)
      |=> (o_shrt && o_code == `HGC_FLT_SHORT))
      else $error("shorted load not latched at blank end");
   AST_CH_IDLE_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !i_en |=> (q.st == hgc_pkg::CH_IDLE && !o_shrt))
      else $error("diagnostics active while disabled");
endmodule
`default_nettype wire

// File: src/hgc_top.sv
// Six-channel gate control and fault logic top
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.svh"
module hgc_top #(
   parameter int NCH = `HGC_NCH,
   parameter int TURN_ON_BLANK_CYC = `HGC_TURN_ON_BLANK_US * `HGC_CLK_MHZ,
   parameter int TURN_OFF_BLANK_CYC = `HGC_TURN_OFF_BLANK_US * `HGC_CLK_MHZ,
   parameter int GLITCH_FILTER_CYC = `HGC_GLITCH_FILTER_US * `HGC_CLK_MHZ,
   parameter int RETRY_REFRESH_CYC = `HGC_REFRESH_SHORT_MS * 1000 * `HGC_CLK_MHZ
) (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_master_enable_soft_reset,
   input wire logic i_output_enable_only,
   input wire logic [5:0] i_par_in,
   input wire logic [5:0] i_drain_over_short,
   input wire logic [5:0] i_drain_below_open,
   input wire logic [5:0] i_drain_below_gnd,
   input wire logic i_sclk,
   input wire logic i_csb,
   input wire logic i_si,
   output logic o_so,
   output logic [5:0] o_gate_drive_out,
   output logic [1:0] o_short_ref_sel_lo,
   output logic [1:0] o_short_ref_sel_hi,
   output logic o_diag_bias_en
);
   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam logic [1:0] REFRESH_RATIO = 2'(`HGC_REFRESH_LONG_MS / `HGC_REFRESH_SHORT_MS - 1);
   localparam logic [21:0] REFRESH_LAST = 22'(RETRY_REFRESH_CYC - 1);

   hgc_pkg::hgc_top_t q, d;
   logic [15:0] rx_word;
   logic rx_tgl;
   logic [5:0] shrt, waiting;
   logic [11:0] fault_data;
   logic en_both, start_all, frame_new, is_null, any_wait, tap_s, tap_l;
   logic [2:0] addr;
   logic [5:0] wdata;

   // ---------------------------------------------
   // Link side
   // ---------------------------------------------
   hgc_serial u_ser (
      .i_sclk(i_sclk),
      .i_rstn(i_rstn),
      .i_csb(i_csb),
      .i_si(i_si),
      .i_fault_data(q.snap),
      .o_so(o_so),
      .o_rx_word(rx_word),
      .o_rx_tgl(rx_tgl)
   );

   // ---------------------------------------------
   // Channels
   // ---------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi = gi + 1)
      begin : g_ch
         hgc_chan #(
            .TURN_ON_BLANK(16'(TURN_ON_BLANK_CYC)),
            .TURN_OFF_BLANK(16'(TURN_OFF_BLANK_CYC)),
            .GLITCH_FILTER(16'(GLITCH_FILTER_CYC))
         ) u_ch (
            .i_core_clk(i_core_clk),
            .i_rstn(i_rstn),
            .i_en(en_both),
            .i_clr(!q.e1_s),
            .i_start_all(start_all),
            .i_cmd(q.in_s[gi] | q.gsel[gi]),
            .i_over_short(q.os_s[gi]),
            .i_below_open(q.op_s[gi]),
            .i_below_gnd(q.gd_s[gi]),
            .i_latch_mode(q.mode[gi]),
            .i_tap((gi < 3) ? (q.refr[`HGC_REFR_SEL_LO] ? tap_l : tap_s)
                            : (q.refr[`HGC_REFR_SEL_HI] ? tap_l : tap_s)),
            .o_shrt(shrt[gi]),
            .o_wait(waiting[gi]),
            .o_code(fault_data[2 * gi + 1 : 2 * gi])
         );
      end
   endgenerate

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb
   begin
      d = q;
      // Pins pass two flops before use
      d.e1_m = i_master_enable_soft_reset;
      d.e1_s = q.e1_m;
      d.e2_m = i_output_enable_only;
      d.e2_s = q.e2_m;
      d.in_m = i_par_in;
      d.in_s = q.in_m;
      d.os_m = i_drain_over_short;
      d.os_s = q.os_m;
      d.op_m = i_drain_below_open;
      d.op_s = q.op_m;
      d.gd_m = i_drain_below_gnd;
      d.gd_s = q.gd_m;
      d.csb_m = i_csb;
      d.csb_s = q.csb_m;
      d.tg_m = rx_tgl;
      d.tg_s = q.tg_m;
      d.tg_p = q.tg_s;
      en_both = q.e1_s & q.e2_s;
      d.en_p = en_both;
      start_all = en_both & !q.en_p;
      d.diag = en_both;
      frame_new = q.tg_s ^ q.tg_p;
      addr = rx_word[`HGC_ADDR_MSB:`HGC_ADDR_LSB];
      wdata = rx_word[`HGC_DATA_MSB:0];
      is_null = addr[2];
      if (frame_new && !is_null)
      begin
         case (addr)
            `HGC_ADDR_GATE:
            begin
               if (q.e1_s)
                  d.gsel = wdata;
            end
            `HGC_ADDR_MODE: d.mode = wdata;
            `HGC_ADDR_REFR: d.refr = wdata;
            `HGC_ADDR_MASK: d.mask = wdata;
            default: d.mask = q.mask;
         endcase
      end
      if (!q.e1_s)
         d.gsel = `HGC_REG_RESET;
      // Gate equation; second enable only gates, bits kept
      d.gate = {NCH{en_both}} & ~shrt & (q.in_s | q.gsel);
      // Fault data frozen while a frame is open
      if (q.csb_s)
         d.snap = fault_data;
      // Shared refresh timer, runs only while someone waits
      any_wait = |waiting;
      if (any_wait)
      begin
         d.rcnt = q.rcnt + 22'h1;
         if (q.rcnt == REFRESH_LAST)
         begin
            d.rcnt = 22'h0;
            d.rq = q.rq + 2'h1;
         end
      end
      else
      begin
         d.rcnt = 22'h0;
         d.rq = 2'h0;
      end
   end

   assign tap_s = any_wait && (q.rcnt == REFRESH_LAST);
   assign tap_l = tap_s && (q.rq == REFRESH_RATIO);

   always_ff @(posedge i_core_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         q <= '0;
      else
         q <= d;
   end

   assign o_gate_drive_out = q.gate;
   assign o_short_ref_sel_lo = q.refr[1:0];
   assign o_short_ref_sel_hi = q.refr[4:3];
   assign o_diag_bias_en = q.diag;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   sequence s_frame_null;
      frame_new && is_null;
   endsequence
   sequence s_regs_kept;
      q.gsel == $past(q.gsel) && q.mode == $past(q.mode) && q.refr == $past(q.refr);
   endsequence

   AST_NULL_NO_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      s_frame_null and q.e1_s |=> s_regs_kept)
      else $error("null frame changed a register");
   AST_GATE_EQ: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      1'b1 |=> o_gate_drive_out == ($past({NCH{q.e1_s & q.e2_s}}) & ~$past(shrt)
         & ($past(q.in_s) | $past(q.gsel))))
      else $error("gate output off equation");
   AST_E2_LOW_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (!q.e2_s && q.e1_s) |=> (o_gate_drive_out == 6'h00 && q.gsel == $past(q.gsel)
         || $past(frame_new)))
      else $error("second enable low mishandled");
   AST_E1_LOW_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !q.e1_s |=> (q.gsel == 6'h00 && o_gate_drive_out == 6'h00))
      else $error("first enable low did not clear");
   AST_E1_LOW_CFG: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (!q.e1_s && frame_new && addr == `HGC_ADDR_MODE) |=> q.mode == $past(wdata))
      else $error("config write lost while first enable low");
   AST_DIAG_EN: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      1'b1 |=> o_diag_bias_en == $past(q.e1_s & q.e2_s))
      else $error("diagnostic enable wrong");
   AST_SNAP_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (!q.csb_s ##1 !q.csb_s) |-> q.snap == $past(q.snap))
      else $error("fault snapshot moved during frame");
   AST_TAP_SPACING: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (any_wait && q.rcnt == 22'h0 && q.rq == 2'h0) ##1 any_wait[*8] |-> !tap_s)
      else $error("refresh tap too early");

   sequence s_wr_mode;
      frame_new && addr == `HGC_ADDR_MODE;
   endsequence
   sequence s_wr_refr;
      frame_new && addr == `HGC_ADDR_REFR;
   endsequence

   AST_MODE_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      s_wr_mode |=> q.mode == $past(wdata))
      else $error("mode write lost");
   AST_REFR_WRITE: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      s_wr_refr |=> (o_short_ref_sel_lo == $past(wdata[1:0])
         && o_short_ref_sel_hi == $past(wdata[4:3])))
      else $error("threshold select write lost");
   AST_SHORT_GATE_OFF: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      1'b1 |=> (o_gate_drive_out & $past(shrt)) == 6'h00)
      else $error("shorted channel still driven");
   AST_E1_FAULT_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !q.e1_s |=> fault_data == 12'h000)
      else $error("fault codes kept while first enable low");
   AST_TIMER_IDLE: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !any_wait |=> (q.rcnt == 22'h0 && q.rq == 2'h0))
      else $error("refresh timer runs with no channel waiting");
   AST_SNAP_FOLLOW: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      q.csb_s |=> q.snap == $past(fault_data))
      else $error("fault snapshot not refreshed between frames");
endmodule
`default_nettype wire

// File: sim/hgc_host_model.sv
// Host serial master model driving the gate control link
`timescale 1ns/1ps
`default_nettype none
module hgc_host_model (
   output logic o_sclk,
   output logic o_csb,
   output logic o_si,
   input wire logic i_so
);
   // -----
   // Idle levels
   // -----
   initial
   begin
      o_sclk = 1'b0;
      o_csb = 1'b1;
      o_si = 1'b0;
   end
   // -----
   // Frame engine
   // -----
   // Link clock stands still outside frames; 32 ns period inside
   task automatic xfer(input logic [15:0] i_word, output logic [15:0] o_resp);
      o_csb = 1'b0;
      #60;
      for (int i = 15; i >= 0; i--)
      begin
         o_si = i_word[i];
         o_resp[i] = i_so;
         #16 o_sclk = 1'b1;
         #16 o_sclk = 1'b0;
      end
      #16 o_csb = 1'b1;
      // Released data line flips so no stale bit is mistaken for data
      o_si = ~o_si;
      // Long gap lets the write land and the snapshot refresh
      #200;
   endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the six-channel gate control top
`timescale 1ns/1ps
`default_nettype none
`include "hgc_map.svh"
module tb;
   logic core_clk, rstn, en1, en2, sclk, csb, si, so, diag, prev;
   logic [5:0] par, ov, op, gn, gate;
   logic [1:0] sel_lo, sel_hi;
   logic [15:0] resp;
   int miscompares, samples_checked, cyc, rises;
   // -----
   // Design and host
   // -----
   // Short timer values keep the run brief
   hgc_top #(.TURN_ON_BLANK_CYC(20), .TURN_OFF_BLANK_CYC(20),
      .GLITCH_FILTER_CYC(10), .RETRY_REFRESH_CYC(200)) uut (
      .i_core_clk(core_clk),
      .i_rstn(rstn),
      .i_master_enable_soft_reset(en1),
      .i_output_enable_only(en2),
      .i_par_in(par),
      .i_drain_over_short(ov),
      .i_drain_below_open(op),
      .i_drain_below_gnd(gn),
      .i_sclk(sclk),
      .i_csb(csb),
      .i_si(si),
      .o_so(so),
      .o_gate_drive_out(gate),
      .o_short_ref_sel_lo(sel_lo),
      .o_short_ref_sel_hi(sel_hi),
      .o_diag_bias_en(diag)
   );
   hgc_host_model host (
      .o_sclk(sclk),
      .o_csb(csb),
      .o_si(si),
      .i_so(so)
   );
   // -----
   // Clock and timeout
   // -----
   always #10 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         test_done();
      end
   end
   // -----
   // Helpers
   // -----
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wr(input logic [2:0] addr, input logic [5:0] data);
      host.xfer({7'h00, addr, data}, resp);
      tick(1);
   endtask
   task automatic rd(input logic [11:0] exp);
      host.xfer({7'h00, `HGC_ADDR_NULL, 6'h00}, resp);
      tick(1);
      check(resp, {4'h0, exp}, "fault data");
   endtask
   task automatic gate_is(input logic [5:0] exp);
      check({10'h000, gate}, {10'h000, exp}, "gate");
   endtask
   task automatic test_done();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // -----
   // Scenarios
   // -----
   initial
   begin
      core_clk = 1'b0;
      rstn = 1'b0;
      en1 = 1'b0;
      en2 = 1'b0;
      par = 6'h00;
      ov = 6'h00;
      op = 6'h00;
      gn = 6'h00;
      tick(6);
      gate_is(6'h00);
      rstn = 1'b1;
      en1 = 1'b1;
      en2 = 1'b1;
      par = 6'h15;
      tick(8);
      gate_is(6'h15);
      check({15'h0000, diag}, 16'h0001, "diag on");
      wr(`HGC_ADDR_GATE, 6'h2A);
      check(resp, 16'h0000, "write response");
      tick(4);
      gate_is(6'h3F);
      en2 = 1'b0;
      tick(5);
      gate_is(6'h00);
      check({15'h0000, diag}, 16'h0000, "diag off");
      en2 = 1'b1;
      tick(5);
      gate_is(6'h3F);
      par = 6'h00;
      tick(5);
      gate_is(6'h2A);
      en1 = 1'b0;
      tick(5);
      gate_is(6'h00);
      wr(`HGC_ADDR_GATE, 6'h01);
      wr(`HGC_ADDR_REFR, 6'h1B);
      check({12'h000, sel_hi, sel_lo}, 16'h000F, "ref select");
      wr(`HGC_ADDR_MODE, 6'h08);
      en1 = 1'b1;
      tick(30);
      gate_is(6'h00);
      wr(`HGC_ADDR_REFR, 6'h11);
      check({12'h000, sel_hi, sel_lo}, 16'h0009, "ref select");
      // Every address with the top bit set must leave registers alone
      for (int a = 4; a < 8; a++)
      begin
         wr(a[2:0], 6'h3F);
         check({12'h000, sel_hi, sel_lo}, 16'h0009, "null frame");
         gate_is(6'h00);
         check(resp, 16'h0000, "null response");
      end
      op[1] = 1'b1;
      op[2] = 1'b1;
      gn[2] = 1'b1;
      tick(40);
      rd(12'h024);
      wr(`HGC_ADDR_MODE, 6'h08);
      ov[3] = 1'b1;
      tick(40);
      rd(12'h024);
      par[3] = 1'b1;
      tick(40);
      gate_is(6'h00);
      rd(12'h0E4);
      tick(300);
      gate_is(6'h00);
      ov[3] = 1'b0;
      par[3] = 1'b0;
      tick(40);
      par[3] = 1'b1;
      tick(40);
      gate_is(6'h08);
      // Long refresh on channels 3 to 5: one retry only in the window
      wr(`HGC_ADDR_REFR, 6'h31);
      check({12'h000, sel_hi, sel_lo}, 16'h0009, "ref select");
      // Persistent short in auto-retry must pulse the output again
      ov[4] = 1'b1;
      par[4] = 1'b1;
      rises = 0;
      for (int i = 0; i < 1000; i++)
      begin
         prev = gate[4];
         tick(1);
         if (gate[4] && !prev)
            rises++;
      end
      check({15'h0000, rises == 2}, 16'h0001, "retry pulses");
      en1 = 1'b0;
      tick(5);
      rd(12'h000);
      gate_is(6'h00);
      test_done();
   end
endmodule
`default_nettype wire
